//--- rtl/dsf_status.sv
// driver status word: flags, fault latches and register read port
module dsf_status
   import dsf_pkg::*;
#(
   parameter int STST_CLOCKS = DSF_STST_CLOCKS
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic STEP,
   input wire logic DRIVER_ENABLE_N,
   input wire logic [DSF_OFF_TIME_W-1:0] CHOPPER_OFF_TIME,
   input wire logic VOLTAGE_MODE_SEL,
   input wire logic [DSF_CS_W-1:0] CS_ACTUAL,
   input wire dsf_temp_t TEMP_CMP,
   input wire logic [1:0] OPEN_LOAD,
   input wire dsf_short_t SHORT_DET,
   input wire logic OT_LIMIT_HIT,
   input wire logic OTPW_HIT,
   input wire logic RD_EN,
   input wire logic [6:0] RD_ADDR,
   output logic [31:0] RD_DATA,
   output logic RD_VALID,
   output logic BRIDGE_DISABLE
);
   // ----------------------------------------------------------------
   // step edge and standstill
   // ----------------------------------------------------------------
   logic step_prev_r;
   logic step_edge;
   logic standstill;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         step_prev_r <= 1'b0;
      end else begin
         step_prev_r <= STEP;
      end
   end

   assign step_edge = STEP & ~step_prev_r;

   dsf_idle_timer #(
      .STST_CLOCKS(STST_CLOCKS)
   ) u_idle (
      .clk(CLK),
      .reset(RESET),
      .step_edge(step_edge),
      .standstill(standstill)
   );

   // ----------------------------------------------------------------
   // short flags, one set per chopper mode
   // ----------------------------------------------------------------
   logic driver_off;
   logic [3:0] short_set [2];
   dsf_short_t short_r [2];
   dsf_short_t short_nxt [2];

   assign driver_off = DRIVER_ENABLE_N | (CHOPPER_OFF_TIME == '0);

   always_comb begin
      for (int m = 0; m < 2; m++) begin
         short_set[m] = (VOLTAGE_MODE_SEL == m[0]) ? SHORT_DET : 4'h0;
         if (driver_off) begin
            short_nxt[m] = short_set[m];
         end else begin
            short_nxt[m] = short_r[m] | short_set[m];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         short_r[0] <= '0;
         short_r[1] <= '0;
      end else begin
         short_r[0] <= short_nxt[0];
         short_r[1] <= short_nxt[1];
      end
   end

   // ----------------------------------------------------------------
   // overtemperature latch, shared by both bridges
   // ----------------------------------------------------------------
   logic ot_r;
   logic ot_nxt;

   always_comb begin
      if (OT_LIMIT_HIT) begin
         ot_nxt = 1'b1;
      end else if (!OTPW_HIT) begin
         ot_nxt = 1'b0;
      end else begin
         ot_nxt = ot_r;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ot_r <= 1'b0;
      end else begin
         ot_r <= ot_nxt;
      end
   end

   // open load takes no part in the bridge decision
   always_ff @(posedge CLK) begin
      if (RESET) begin
         BRIDGE_DISABLE <= 1'b0;
      end else begin
         BRIDGE_DISABLE <= (|short_nxt[0]) | (|short_nxt[1]) | ot_nxt;
      end
   end

   // ----------------------------------------------------------------
   // status word and read port
   // ----------------------------------------------------------------
   logic [31:0] word;
   dsf_short_t short_view;

   assign short_view = short_r[VOLTAGE_MODE_SEL];

   always_comb begin
      word = 32'h0000_0000;
      word[DSF_STST_BIT] = standstill;
      word[DSF_VMODE_BIT] = VOLTAGE_MODE_SEL;
      word[DSF_CS_MSB:DSF_CS_LSB] = CS_ACTUAL;
      word[DSF_TEMP_MSB:DSF_TEMP_LSB] = TEMP_CMP;
      word[DSF_OPEN_MSB:DSF_OPEN_LSB] = OPEN_LOAD;
      word[DSF_SHORT_MSB:DSF_SHORT_LSB] = short_view;
      word[DSF_OT_BIT] = ot_r;
      word[DSF_OTPW_BIT] = OTPW_HIT;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= RD_EN && (RD_ADDR == DSF_STATUS_ADDR);
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         RD_DATA <= DSF_RD_DATA_RST;
      end else if (RD_EN && (RD_ADDR == DSF_STATUS_ADDR)) begin
         RD_DATA <= word;
      end else begin
         RD_DATA <= DSF_RD_DATA_RST;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);

   localparam logic [DSF_STST_CW-1:0] CHK_LIMIT = DSF_STST_CW'(STST_CLOCKS);
   logic [DSF_STST_CW-1:0] idle_chk_r;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         idle_chk_r <= '0;
      end else if (STEP && !step_prev_r) begin
         idle_chk_r <= '0;
      end else if (idle_chk_r != CHK_LIMIT) begin
         idle_chk_r <= idle_chk_r + DSF_STST_CW'(1);
      end
   end

   AST_STST_MATCH: assert property (standstill == (idle_chk_r == CHK_LIMIT))
      else $error("standstill flag disagrees with idle clock count");

   AST_STST_STEP_CLEARS: assert property ((STEP && !step_prev_r) |=> !standstill)
      else $error("standstill still set after a step edge");

   AST_MODE_BIT: assert property (RD_VALID |-> RD_DATA[DSF_VMODE_BIT] == $past(VOLTAGE_MODE_SEL))
      else $error("chopper mode bit does not follow mode select");

   AST_CS_FIELD: assert property (RD_VALID |-> RD_DATA[DSF_CS_MSB:DSF_CS_LSB] == $past(CS_ACTUAL))
      else $error("current scale field wrong");

   AST_TEMP_FIELD: assert property (RD_VALID |-> RD_DATA[DSF_TEMP_MSB:DSF_TEMP_LSB] == $past(TEMP_CMP))
      else $error("temperature comparator bits wrong");

   AST_OPEN_NO_ACTION: assert property (
      ($past(SHORT_DET) == 4'h0 && !$past(OT_LIMIT_HIT) && $past(short_r[0]) == 4'h0
       && $past(short_r[1]) == 4'h0 && !$past(ot_r)) |-> !BRIDGE_DISABLE)
      else $error("bridges disabled without a short or overtemperature");

   AST_OPEN_FIELD: assert property (RD_VALID |-> RD_DATA[DSF_OPEN_MSB:DSF_OPEN_LSB] == $past(OPEN_LOAD))
      else $error("open load bits wrong");

   AST_BRIDGE_CAUSE: assert property (BRIDGE_DISABLE |-> (short_r[0] | short_r[1]) != 4'h0 || ot_r)
      else $error("bridges disabled with no fault flag held");

   // ----------------------------------------------------------------
   // short flag checks
   // ----------------------------------------------------------------
   AST_SHORT_DISABLES: assert property ((SHORT_DET != 4'h0) |=> BRIDGE_DISABLE)
      else $error("short detection did not disable bridges");

   AST_LS_SHORT_DISABLES: assert property (SHORT_DET[3:2] != 2'b00 |=> BRIDGE_DISABLE)
      else $error("low-side short did not disable bridges");

   AST_GND_SHORT_DISABLES: assert property (SHORT_DET[1:0] != 2'b00 |=> BRIDGE_DISABLE)
      else $error("ground short did not disable bridges");

   AST_SHORT_LATCH: assert property (
      (SHORT_DET != 4'h0 && !driver_off) ##1 (!driver_off && SHORT_DET == 4'h0)
      |-> (short_r[VOLTAGE_MODE_SEL] | short_r[!VOLTAGE_MODE_SEL]) != 4'h0)
      else $error("short flags lost while driver is on");

   AST_SHORT_CLEAR_OFF: assert property (
      (driver_off && SHORT_DET == 4'h0) |=> short_r[0] == 4'h0 && short_r[1] == 4'h0)
      else $error("short flags survive driver switch-off");

   AST_OFF_TIME_CLEARS: assert property (
      (!DRIVER_ENABLE_N && CHOPPER_OFF_TIME == '0 && SHORT_DET == 4'h0)
      |=> (short_r[0] | short_r[1]) == 4'h0 && (!BRIDGE_DISABLE || ot_r))
      else $error("zero off-time did not clear short flags");

   AST_ENABLE_CLEARS: assert property (
      (DRIVER_ENABLE_N && SHORT_DET == 4'h0) |=> (short_r[0] | short_r[1]) == 4'h0)
      else $error("enable release did not clear short flags");

   AST_SHORT_SET_WINS: assert property (
      (driver_off && SHORT_DET != 4'h0) |=> (short_r[0] | short_r[1]) == $past(SHORT_DET))
      else $error("short detected during switch-off was dropped");

   AST_SHORT_HOLD0: assert property ((!driver_off && short_r[0] != 4'h0) |=> short_r[0] != 4'h0)
      else $error("current chopper short set lost while driver on");

   AST_SHORT_HOLD1: assert property ((!driver_off && short_r[1] != 4'h0) |=> short_r[1] != 4'h0)
      else $error("quiet chopper short set lost while driver on");

   AST_MODE_SEPARATE: assert property (
      (SHORT_DET != 4'h0 && VOLTAGE_MODE_SEL && !driver_off && short_r[0] == 4'h0)
      |=> short_r[0] == 4'h0 && short_r[1] != 4'h0)
      else $error("short in one mode leaked into the other set");

   AST_MODE_SEPARATE0: assert property (
      (SHORT_DET != 4'h0 && !VOLTAGE_MODE_SEL && !driver_off && short_r[1] == 4'h0)
      |=> short_r[1] == 4'h0 && short_r[0] != 4'h0)
      else $error("current chopper short leaked into quiet set");

   // ----------------------------------------------------------------
   // overtemperature checks
   // ----------------------------------------------------------------
   AST_OT_HOLD: assert property ((ot_r && OTPW_HIT) |=> ot_r && BRIDGE_DISABLE)
      else $error("overtemperature released before prewarning cleared");

   AST_OT_SET: assert property (OT_LIMIT_HIT |=> ot_r ##0 BRIDGE_DISABLE)
      else $error("overtemperature limit did not latch");

   AST_OT_CLEAR: assert property ((!OT_LIMIT_HIT && !OTPW_HIT) |=> !ot_r)
      else $error("overtemperature latch held after cooling");

   AST_OTPW_NO_SET: assert property ((!ot_r && !OT_LIMIT_HIT) |=> !ot_r)
      else $error("prewarning alone latched overtemperature");

   // ----------------------------------------------------------------
   // read data and standstill checks
   // ----------------------------------------------------------------
   AST_STST_BIT: assert property (RD_VALID |-> RD_DATA[DSF_STST_BIT] == $past(standstill))
      else $error("standstill bit wrong");

   AST_STST_HOLD: assert property ((standstill && !(STEP && !step_prev_r)) |=> standstill)
      else $error("standstill dropped without a step edge");

   AST_SHORT_FIELD: assert property (
      RD_VALID |-> RD_DATA[DSF_SHORT_MSB:DSF_SHORT_LSB] == $past(VOLTAGE_MODE_SEL ? short_r[1] : short_r[0]))
      else $error("short flag bits do not show the active mode set");

   AST_OT_BIT: assert property (RD_VALID |-> RD_DATA[DSF_OT_BIT] == $past(ot_r))
      else $error("overtemperature bit wrong");

   AST_OTPW_BIT: assert property (RD_VALID |-> RD_DATA[DSF_OTPW_BIT] == $past(OTPW_HIT))
      else $error("prewarning bit wrong");

   AST_RESERVED_ZERO: assert property (RD_VALID |-> RD_DATA[29:21] == 9'h000 && RD_DATA[15:12] == 4'h0)
      else $error("reserved bits not zero");

   AST_READ_ANSWER: assert property ((RD_EN && RD_ADDR == DSF_STATUS_ADDR) |=> RD_VALID)
      else $error("read of the status word not answered");

   AST_UNMAPPED_IDLE: assert property ((!RD_EN || RD_ADDR != DSF_STATUS_ADDR) |=> !RD_VALID && RD_DATA == 32'h0)
      else $error("answer given to unmapped read");

   COV_STANDSTILL: cover property ($rose(standstill));
   COV_SHORT_CLEAR: cover property ((short_r[0] != 4'h0) ##1 driver_off ##1 (short_r[0] == 4'h0));
   COV_OT_CYCLE: cover property ($rose(ot_r) ##[1:20] $fell(ot_r));
   COV_READ: cover property (RD_VALID && RD_DATA[DSF_VMODE_BIT]);
   COV_SHORT_MODE1: cover property (short_r[1] != 4'h0 && !VOLTAGE_MODE_SEL);
endmodule

//--- rtl/dsf_pkg.sv
// shared constants and types of the driver status flag block
package dsf_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [6:0] DSF_STATUS_ADDR = 7'h6F;
   localparam logic [31:0] DSF_RD_DATA_RST = 32'h0000_0000;

   // ----------------------------------------------------------------
   // field positions of the status word
   // ----------------------------------------------------------------
   localparam int DSF_STST_BIT = 31;
   localparam int DSF_VMODE_BIT = 30;
   localparam int DSF_CS_MSB = 20;
   localparam int DSF_CS_LSB = 16;
   localparam int DSF_TEMP_MSB = 11;
   localparam int DSF_TEMP_LSB = 8;
   localparam int DSF_OPEN_MSB = 7;
   localparam int DSF_OPEN_LSB = 6;
   localparam int DSF_SHORT_MSB = 5;
   localparam int DSF_SHORT_LSB = 2;
   localparam int DSF_OT_BIT = 1;
   localparam int DSF_OTPW_BIT = 0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int DSF_STST_CLOCKS = 2 ** 20;
   localparam int DSF_STST_CW = 21;
   localparam int DSF_OFF_TIME_W = 4;
   localparam int DSF_CS_W = 5;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   // short detector inputs, ordered as status bits 5..2
   typedef struct packed {
      logic lowside_short_phase_b;
      logic lowside_short_phase_a;
      logic ground_short_phase_b;
      logic ground_short_phase_a;
   } dsf_short_t;

   typedef struct packed {
      logic temp_cmp_top;
      logic temp_cmp_high;
      logic temp_cmp_mid;
      logic temp_cmp_low;
   } dsf_temp_t;
endpackage

//--- rtl/dsf_idle_timer.sv
// standstill timer: counts clocks since the last step edge
module dsf_idle_timer
   import dsf_pkg::*;
#(
   parameter int STST_CLOCKS = DSF_STST_CLOCKS
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic step_edge,
   output logic standstill
);
   localparam logic [DSF_STST_CW-1:0] LIMIT = DSF_STST_CW'(STST_CLOCKS);

   logic [DSF_STST_CW-1:0] cnt_r;
   logic [DSF_STST_CW-1:0] cnt_nxt;

   always_comb begin
      if (step_edge) begin
         cnt_nxt = '0;
      end else if (cnt_r != LIMIT) begin
         cnt_nxt = cnt_r + DSF_STST_CW'(1);
      end else begin
         cnt_nxt = cnt_r;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         standstill <= 1'b0;
      end else begin
         standstill <= (cnt_nxt == LIMIT);
      end
   end
endmodule

//--- tb/test_driver_status_flags.sv
// self-checking bench of the driver status word
module test_driver_status_flags;
   timeunit 1ns;
   timeprecision 1ps;
   import dsf_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam int STST = 16;
   localparam logic [31:0] MASK = 32'hC01F_0FFF;
   logic CLK, RESET, STEP, DRIVER_ENABLE_N, VOLTAGE_MODE_SEL, OT_LIMIT_HIT, OTPW_HIT;
   logic RD_EN, RD_VALID, BRIDGE_DISABLE;
   logic [DSF_OFF_TIME_W-1:0] CHOPPER_OFF_TIME;
   logic [DSF_CS_W-1:0] CS_ACTUAL;
   dsf_temp_t TEMP_CMP;
   logic [1:0] OPEN_LOAD;
   dsf_short_t SHORT_DET;
   logic [6:0] RD_ADDR;
   logic [31:0] RD_DATA;
   int errors;
   int tests_run;
   logic [31:0] exp_q[$];
   logic [31:0] seed = 32'hC57A5485;
   logic m_stst, m_ot;
   logic [3:0] m_sh0, m_sh1;

   dsf_status #(.STST_CLOCKS(STST)) dut (.CLK(CLK), .RESET(RESET), .STEP(STEP),
      .DRIVER_ENABLE_N(DRIVER_ENABLE_N), .CHOPPER_OFF_TIME(CHOPPER_OFF_TIME),
      .VOLTAGE_MODE_SEL(VOLTAGE_MODE_SEL), .CS_ACTUAL(CS_ACTUAL), .TEMP_CMP(TEMP_CMP),
      .OPEN_LOAD(OPEN_LOAD), .SHORT_DET(SHORT_DET), .OT_LIMIT_HIT(OT_LIMIT_HIT), .OTPW_HIT(OTPW_HIT),
      .RD_EN(RD_EN), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
      .BRIDGE_DISABLE(BRIDGE_DISABLE));

   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] exp_word();
      logic [31:0] w;
      w = 32'h0000_0000;
      w[31] = m_stst;
      w[30] = VOLTAGE_MODE_SEL;
      w[20:16] = CS_ACTUAL;
      w[11:8] = TEMP_CMP;
      w[7:6] = OPEN_LOAD;
      w[5:2] = VOLTAGE_MODE_SEL ? m_sh1 : m_sh0;
      w[1] = m_ot;
      w[0] = OTPW_HIT;
      return w;
   endfunction

   task automatic tick(int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask

   task automatic check_word(logic [31:0] e, logic [31:0] s);
      tests_run++;
      if ((s & MASK) !== (e & MASK)) begin
         errors++;
         $display("CHECK FAILED status word expected %h seen %h", e, s);
      end
   endtask

   task automatic check_bit(string n, logic e, logic s);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, s);
      end
   endtask

   task automatic rd(logic [6:0] a);
      RD_EN = 1'b1;
      RD_ADDR = a;
      if (a == DSF_STATUS_ADDR) exp_q.push_back(exp_word());
      tick(1);
      RD_EN = 1'b0;
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // read monitor
   // ----------------------------------------------------------------
   always @(negedge CLK) begin
      if (RD_VALID === 1'b1) begin
         if (exp_q.size() == 0) check_bit("unexpected read valid", 1'b0, RD_VALID);
         else check_word(exp_q.pop_front(), RD_DATA);
      end
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      RESET = 1'b1; STEP = 1'b0; DRIVER_ENABLE_N = 1'b0; CHOPPER_OFF_TIME = 4'h3;
      VOLTAGE_MODE_SEL = 1'b0; CS_ACTUAL = '0; TEMP_CMP = '0; OPEN_LOAD = 2'h0; SHORT_DET = '0;
      OT_LIMIT_HIT = 1'b0; OTPW_HIT = 1'b0; RD_EN = 1'b0; RD_ADDR = 7'h00;
      m_stst = 1'b1; m_ot = 1'b0; m_sh0 = 4'h0; m_sh1 = 4'h0; errors = 0; tests_run = 0;
      tick(4);
      RESET = 1'b0;
      tick(STST + 4);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         {VOLTAGE_MODE_SEL, CS_ACTUAL, TEMP_CMP, OPEN_LOAD, OTPW_HIT} = seed[12:0];
         tick(1);
         rd(DSF_STATUS_ADDR);
         check_bit("bridge with open load", 1'b0, BRIDGE_DISABLE);
      end
      {VOLTAGE_MODE_SEL, OPEN_LOAD, OTPW_HIT} = 4'h0;
      $display("live field test done");
      for (int i = 0; i < 8; i++) begin
         VOLTAGE_MODE_SEL = i[2];
         tick(1);
         SHORT_DET = dsf_short_t'(4'h1 << i[1:0]);
         tick(1);
         SHORT_DET = '0;
         if (i[2]) m_sh1 = 4'h1 << i[1:0];
         else m_sh0 = 4'h1 << i[1:0];
         tick(1);
         rd(DSF_STATUS_ADDR);
         check_bit("bridge on short", 1'b1, BRIDGE_DISABLE);
         VOLTAGE_MODE_SEL = ~i[2];
         tick(2);
         rd(DSF_STATUS_ADDR);
         if (i[0]) CHOPPER_OFF_TIME = 4'h0;
         else DRIVER_ENABLE_N = 1'b1;
         tick(1);
         CHOPPER_OFF_TIME = 4'h3;
         DRIVER_ENABLE_N = 1'b0;
         m_sh0 = 4'h0;
         m_sh1 = 4'h0;
         tick(1);
         rd(DSF_STATUS_ADDR);
         check_bit("bridge after off", 1'b0, BRIDGE_DISABLE);
      end
      $display("short flag test done");
      OT_LIMIT_HIT = 1'b1; OTPW_HIT = 1'b1; m_ot = 1'b1;
      tick(2);
      rd(DSF_STATUS_ADDR);
      check_bit("bridge on overheat", 1'b1, BRIDGE_DISABLE);
      OT_LIMIT_HIT = 1'b0;
      tick(2);
      rd(DSF_STATUS_ADDR);
      check_bit("bridge while prewarning", 1'b1, BRIDGE_DISABLE);
      OTPW_HIT = 1'b0; m_ot = 1'b0;
      tick(2);
      rd(DSF_STATUS_ADDR);
      check_bit("bridge after cooling", 1'b0, BRIDGE_DISABLE);
      $display("overtemperature test done");
      tick(1);
      rd(7'h6E);
      check_bit("unmapped valid", 1'b0, RD_VALID);
      check_word(32'h0000_0000, RD_DATA);
      $display("unmapped read test done");
      // read lands at STST then STST+1 clocks after the step edge
      for (int k = STST; k <= STST + 1; k++) begin
         STEP = 1'b1;
         tick(1);
         STEP = 1'b0;
         m_stst = 1'b0;
         tick(2);
         rd(DSF_STATUS_ADDR);
         tick(k - 4);
         m_stst = (k > STST);
         rd(DSF_STATUS_ADDR);
      end
      $display("standstill test done");
      for (int k = 0; k < 10 && exp_q.size() > 0; k++) tick(1);
      if (exp_q.size() > 0) check_bit("read answered", 1'b1, 1'b0);
      stop_test();
   end
endmodule
